// *** src/hv_lock_pkg.sv ***
package hv_lock_pkg;

  // ==========================================================================
  // Command byte layout and memory locations
  // ==========================================================================
  localparam logic [3:0] ADDR_WIPER0    = 4'h0;
  localparam logic [3:0] ADDR_WIPER1    = 4'h1;
  localparam logic [3:0] ADDR_LOCK0     = 4'h2;
  localparam logic [3:0] ADDR_LOCK1     = 4'h3;
  localparam logic [3:0] ADDR_TERMINAL_CONTROL_REGISTER      = 4'h4;
  localparam logic [3:0] ADDR_STATUS    = 4'h5;
  localparam logic [3:0] ADDR_PROTECT   = 4'hF;
  localparam logic [1:0] OP_WRITE       = 2'h0;
  localparam logic [1:0] OP_INCREMENT   = 2'h1;
  localparam logic [1:0] OP_DECREMENT   = 2'h2;
  localparam logic [1:0] OP_READ        = 2'h3;
  localparam int         CMD_BITS       = 8;
  localparam int         ERR_BIT_INDEX  = 6;

  // ==========================================================================
  // Wiper range and reset values
  // ==========================================================================
  localparam int         WIPER_W        = 9;
  localparam logic [8:0] WIPER_FULL     = 9'h100;
  localparam logic [8:0] WIPER_ZERO     = 9'h000;
  localparam logic [8:0] WIPER_RESET    = 9'h080;

  // ==========================================================================
  // Timing
  // ==========================================================================
  localparam int SYS_CLK_HZ             = 10_000_000;
  localparam int NV_WRITE_CYCLE_TIME_US = 5000;
  localparam int NV_WRITE_CYCLES =
    (NV_WRITE_CYCLE_TIME_US * (SYS_CLK_HZ / 1_000_000));
  localparam int NV_CNT_W               = 20;

  typedef struct packed {
    logic [3:0] addr;
    logic [1:0] op;
    logic [1:0] data_hi;
  } cmd_byte_s;

  typedef struct packed {
    logic wiper0_position_lock;
    logic wiper1_position_lock;
    logic write_protect;
  } nv_bits_s;

endpackage

// *** src/sync_2ff.sv ***
`timescale 1ns/1ps
`default_nettype none
module sync_2ff #(
  parameter logic RST_VAL = 1'b0 // Idle level of the pin, shown in reset.
) (
  input  wire logic sys_clk, // System clock.
  input  wire logic nrst,    // Asynchronous reset, active low.
  input  wire logic din,     // Asynchronous input.
  output logic      dout     // Synchronised level.
);
  logic meta_q;
  logic meta_d;
  logic sync_d;

  always_comb begin
    meta_d = din;
    sync_d = meta_q;
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      meta_q <= RST_VAL;
      dout   <= RST_VAL;
    end else begin
      meta_q <= meta_d;
      dout   <= sync_d;
    end
  end
endmodule
`default_nettype wire

// *** src/hv_protect_lock_command_handler.sv ***
`timescale 1ns/1ps
`default_nettype none
module hv_protect_lock_command_handler
  import hv_lock_pkg::*;
#(
  parameter int NV_CYCLES = hv_lock_pkg::NV_WRITE_CYCLES
) (
  input  wire logic              sys_clk,          // System clock, 10 MHz.
  input  wire logic              nrst,             // Async reset, active low.
  input  wire logic              cs_n,             // Chip select pin.
  input  wire logic              sck,              // Serial clock pin.
  input  wire logic              sdi,              // Serial data in pin.
  input  wire logic              high_voltage_in,  // Chip select at high level.
  output logic                   sdo_o,            // Serial data out level.
  output logic                   sdo_oe,           // Open-drain pull-low.
  output logic [WIPER_W-1:0]     wiper0_q,         // Volatile wiper 0.
  output logic [WIPER_W-1:0]     wiper1_q,         // Volatile wiper 1.
  output hv_lock_pkg::nv_bits_s  nv_bits_q,        // Lock and protect bits.
  output logic                   nv_write_active_flag, // Write cycle runs.
  output logic                   command_error_flag    // Command error seen.
);
  import hv_lock_pkg::*;

  // ==========================================================================
  // Pin synchronisers
  // ==========================================================================
  logic cs_s;
  logic sck_s;
  logic sdi_s;
  logic hv_s;

  // Each synchroniser resets to its pin's idle level, so that no false
  // edge is seen on the first clocks after reset.
  sync_2ff #(.RST_VAL(1'b1)) u_cs (.sys_clk(sys_clk), .nrst(nrst),
                  .din(cs_n), .dout(cs_s));
  sync_2ff u_sck (.sys_clk(sys_clk), .nrst(nrst), .din(sck),
                  .dout(sck_s));
  sync_2ff u_sdi (.sys_clk(sys_clk), .nrst(nrst), .din(sdi),
                  .dout(sdi_s));
  sync_2ff u_hv  (.sys_clk(sys_clk), .nrst(nrst), .din(high_voltage_in),
                  .dout(hv_s));

  // ==========================================================================
  // Serial shifter and command decode
  // ==========================================================================
  logic                 sck_prev_q, sck_prev_d;
  logic                 cs_prev_q, cs_prev_d;
  logic [CMD_BITS-1:0]  shift_q, shift_d;
  logic [3:0]           bit_cnt_q, bit_cnt_d;
  logic                 err_q, err_d;
  logic                 nv_pend_q, nv_pend_d;
  nv_bits_s             nv_next_q, nv_next_d;
  logic [WIPER_W-1:0]   w0_d, w1_d;
  nv_bits_s             nv_d;
  logic [NV_CNT_W-1:0]  nv_cnt_q, nv_cnt_d;
  logic                 nv_busy_q, nv_busy_d;
  logic                 sdo_d, sdo_oe_d;

  logic      rise, fall, cs_active, cs_release;
  cmd_byte_s cmd;
  logic      byte_done;
  logic [CMD_BITS-1:0] byte_now;

  always_comb begin
    rise       = sck_s & ~sck_prev_q;
    fall       = ~sck_s & sck_prev_q;
    cs_active  = ~cs_s;
    cs_release = cs_s & ~cs_prev_q;
    byte_now   = {shift_q[CMD_BITS-2:0], sdi_s};
    byte_done  = cs_active && rise && (bit_cnt_q == 4'(CMD_BITS - 1));
    cmd        = cmd_byte_s'(byte_now);
  end

  always_comb begin
    sck_prev_d = sck_s;
    cs_prev_d  = cs_s;
    shift_d    = shift_q;
    bit_cnt_d  = bit_cnt_q;
    err_d      = err_q;
    nv_pend_d  = nv_pend_q;
    nv_next_d  = nv_next_q;
    w0_d       = wiper0_q;
    w1_d       = wiper1_q;
    nv_d       = nv_bits_q;
    nv_cnt_d   = nv_cnt_q;
    nv_busy_d  = nv_busy_q;
    if (!cs_active) begin
      bit_cnt_d = 4'h0;
      err_d     = 1'b0;
    end else if (rise) begin
      shift_d = byte_now;
      if (byte_done) begin
        bit_cnt_d = 4'h0;
        if (cmd.op == OP_INCREMENT || cmd.op == OP_DECREMENT) begin
          unique case (cmd.addr)
            ADDR_WIPER0: begin
              if (cmd.op == OP_DECREMENT && wiper0_q != WIPER_ZERO
                  && wiper0_q <= WIPER_FULL)
                w0_d = wiper0_q - 9'h001;
              else if (cmd.op == OP_INCREMENT && wiper0_q < WIPER_FULL)
                w0_d = wiper0_q + 9'h001;
            end
            ADDR_WIPER1: begin
              if (cmd.op == OP_DECREMENT && wiper1_q != WIPER_ZERO
                  && wiper1_q <= WIPER_FULL)
                w1_d = wiper1_q - 9'h001;
              else if (cmd.op == OP_INCREMENT && wiper1_q < WIPER_FULL)
                w1_d = wiper1_q + 9'h001;
            end
            ADDR_LOCK0, ADDR_LOCK1, ADDR_PROTECT: begin
              // Without the high level on chip select, or while the
              // memory is busy, the command is dropped silently.
              if (hv_s && !nv_busy_q && !nv_pend_q) begin
                nv_pend_d = 1'b1;
                nv_next_d = nv_bits_q;
                if (cmd.addr == ADDR_LOCK0)
                  nv_next_d.wiper0_position_lock = (cmd.op == OP_DECREMENT);
                else if (cmd.addr == ADDR_LOCK1)
                  nv_next_d.wiper1_position_lock = (cmd.op == OP_DECREMENT);
                else
                  nv_next_d.write_protect = (cmd.op == OP_DECREMENT);
              end
            end
            default: err_d = 1'b1;
          endcase
        end
      end else begin
        bit_cnt_d = bit_cnt_q + 4'h1;
      end
    end
    // The write starts on release only, so a byte cut short never commits.
    if (nv_busy_q) begin
      if (nv_cnt_q == NV_CNT_W'(NV_CYCLES - 1)) begin
        nv_busy_d = 1'b0;
        nv_d      = nv_next_q;
      end
      nv_cnt_d = nv_cnt_q + NV_CNT_W'(1);
    end else if (cs_release && nv_pend_q) begin
      nv_pend_d = 1'b0;
      nv_busy_d = 1'b1;
      nv_cnt_d  = '0;
    end
  end

  // ==========================================================================
  // Serial output: pulled low on the eighth clock's falling edge, low while error holds
  // ==========================================================================
  always_comb begin
    sdo_d    = sdo_o;
    sdo_oe_d = sdo_oe;
    if (!cs_active) begin
      sdo_d    = 1'b1;
      sdo_oe_d = 1'b0;
    end else if (fall) begin
      if (err_q) begin
        sdo_d    = 1'b0;
        sdo_oe_d = 1'b1;
      end else begin
        sdo_d    = 1'b1;
        sdo_oe_d = 1'b0;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      sck_prev_q <= 1'b0;
      cs_prev_q  <= 1'b1;
      shift_q    <= '0;
      bit_cnt_q  <= 4'h0;
      err_q      <= 1'b0;
      nv_pend_q  <= 1'b0;
      nv_next_q  <= '0;
      wiper0_q   <= WIPER_RESET;
      wiper1_q   <= WIPER_RESET;
      nv_bits_q  <= '0;
      nv_cnt_q   <= '0;
      nv_busy_q  <= 1'b0;
      sdo_o      <= 1'b1;
      sdo_oe     <= 1'b0;
      nv_write_active_flag <= 1'b0;
      command_error_flag   <= 1'b0;
    end else begin
      sck_prev_q <= sck_prev_d;
      cs_prev_q  <= cs_prev_d;
      shift_q    <= shift_d;
      bit_cnt_q  <= bit_cnt_d;
      err_q      <= err_d;
      nv_pend_q  <= nv_pend_d;
      nv_next_q  <= nv_next_d;
      wiper0_q   <= w0_d;
      wiper1_q   <= w1_d;
      nv_bits_q  <= nv_d;
      nv_cnt_q   <= nv_cnt_d;
      nv_busy_q  <= nv_busy_d;
      sdo_o      <= sdo_d;
      sdo_oe     <= sdo_oe_d;
      nv_write_active_flag <= nv_busy_d;
      command_error_flag   <= err_d;
    end
  end
endmodule
`default_nettype wire

// *** verification/hv_lock_monitor.sv ***
`timescale 1ns/1ps
`default_nettype none
module hv_lock_monitor
  import hv_lock_pkg::*;
#(
  parameter int NV_CYCLES = 20
) (
  input wire logic               sys_clk,              // Clock.
  input wire logic               nrst,                 // Reset.
  input wire logic               cs_n,                 // Select.
  input wire logic               sdo_oe,               // Pull low.
  input wire logic [WIPER_W-1:0] wiper0_q,             // Wiper 0.
  input wire logic [WIPER_W-1:0] wiper1_q,             // Wiper 1.
  input wire nv_bits_s           nv_bits_q,            // Lock bits.
  input wire logic               nv_write_active_flag, // Busy.
  input wire logic               command_error_flag    // Error.
);
  // ==========================================================================
  // Helper counters
  // ==========================================================================
  int age_q;
  int run_q;
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      age_q <= 0;
      run_q <= 0;
    end else begin
      age_q <= cs_n ? 0 : (age_q < 99 ? age_q + 1 : age_q);
      run_q <= nv_write_active_flag ? run_q + 1 : 0;
    end
  end
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  chk_start_on_release:
    assert property ($rose(nv_write_active_flag) |-> age_q <= 8)
    else $error("write began without a select release");
  chk_write_length:
    assert property ($fell(nv_write_active_flag) |->
      run_q >= NV_CYCLES - 1 && run_q <= NV_CYCLES + 1)
    else $error("write cycle length wrong");
  chk_bits_at_end:
    assert property ($changed(nv_bits_q) |->
      $past(nv_write_active_flag) || $past(nv_write_active_flag, 2))
    else $error("lock bits changed outside a write end");
  chk_wiper0_step:
    assert property ($changed(wiper0_q) |->
      wiper0_q == 9'($past(wiper0_q) + 9'h001) ||
      wiper0_q == 9'($past(wiper0_q) - 9'h001))
    else $error("wiper 0 moved by more than one step");
  chk_wiper1_step:
    assert property ($changed(wiper1_q) |->
      wiper1_q == 9'($past(wiper1_q) + 9'h001) ||
      wiper1_q == 9'($past(wiper1_q) - 9'h001))
    else $error("wiper 1 moved by more than one step");
  chk_wiper_range:
    assert property (wiper0_q <= WIPER_FULL && wiper1_q <= WIPER_FULL)
    else $error("wiper beyond full scale");
  chk_err_no_change:
    assert property (command_error_flag |->
      $stable(wiper0_q) && $stable(wiper1_q))
    else $error("wiper changed under a command error");
  chk_err_clears:
    assert property ($rose(cs_n) |-> ##[1:6] !command_error_flag)
    else $error("error not cleared by select release");
  chk_sdo_on_err:
    assert property ($rose(sdo_oe) |-> command_error_flag)
    else $error("output pulled low without an error");
endmodule
bind hv_protect_lock_command_handler hv_lock_monitor #(.NV_CYCLES(NV_CYCLES))
  hv_lock_monitor_inst (.sys_clk, .nrst, .cs_n, .sdo_oe, .wiper0_q,
  .wiper1_q, .nv_bits_q, .nv_write_active_flag, .command_error_flag);
`default_nettype wire

// *** verification/hv_spi_host.sv ***
`timescale 1ns/1ps
`default_nettype none
module hv_spi_host (
  input  wire logic sys_clk, // Clock.
  output logic      cs_n,    // Select.
  output logic      sck,     // Link clock, idle low.
  output logic      sdi,     // Data out, MSB first.
  output logic      hv       // Select at high voltage.
);
  // ==========================================================================
  // Host frames, half link period of four clocks
  // ==========================================================================
  initial begin
    cs_n = 1'b1;
    sck  = 1'b0;
    sdi  = 1'b0;
    hv   = 1'b0;
  end
  task automatic select(input logic h);
    @(posedge sys_clk);
    cs_n <= 1'b0;
    hv   <= h;
  endtask
  task automatic release_cs();
    repeat (4) @(posedge sys_clk);
    cs_n <= 1'b1;
    hv   <= 1'b0;
  endtask
  task automatic send(input logic [7:0] b);
    for (int i = 7; i >= 0; i--) begin
      repeat (4) @(posedge sys_clk);
      sck <= 1'b0;
      sdi <= b[i];
      repeat (4) @(posedge sys_clk);
      sck <= 1'b1;
    end
    repeat (4) @(posedge sys_clk);
    sck <= 1'b0;
    // The line is left inverted so a stale bit is never mistaken for data.
    sdi <= ~sdi;
  endtask
endmodule
`default_nettype wire

// *** verification/test_hv_protect_lock_command_handler.sv ***
`timescale 1ns/1ps
`default_nettype none
module test_hv_protect_lock_command_handler;
  import hv_lock_pkg::*;
  logic sys_clk, nrst, cs_n, sck, sdi, hv, sdo_o, sdo_oe, flag, err;
  logic [WIPER_W-1:0] w0, w1;
  nv_bits_s           bits;
  logic [2:0]         m_bits;
  int                 bad_count, n_checks, m_w0, m_w1, seed;
  bit                 m_err, busy;
  hv_spi_host hv_spi_host_inst (.sys_clk(sys_clk), .cs_n(cs_n), .sck(sck),
    .sdi(sdi), .hv(hv));
  // A long write keeps the device busy across a whole second frame.
  hv_protect_lock_command_handler #(.NV_CYCLES(200))
    hv_protect_lock_command_handler_inst (.sys_clk(sys_clk), .nrst(nrst),
    .cs_n(cs_n), .sck(sck), .sdi(sdi), .high_voltage_in(hv), .sdo_o(sdo_o),
    .sdo_oe(sdo_oe), .wiper0_q(w0), .wiper1_q(w1), .nv_bits_q(bits),
    .nv_write_active_flag(flag), .command_error_flag(err));
  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end
  task automatic check(input logic [8:0] seen, input logic [8:0] exp);
    n_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic cmd(input logic [3:0] a, input logic [1:0] op);
    int s;
    s = (op == OP_INCREMENT) ? 1 : -1;
    hv_spi_host_inst.send({a, op, 2'b00});
    repeat (5) @(posedge sys_clk);
    if (a == ADDR_WIPER0 && m_w0 + s inside {[0:256]}) m_w0 += s;
    if (a == ADDR_WIPER1 && m_w1 + s inside {[0:256]}) m_w1 += s;
    if (a inside {ADDR_LOCK0, ADDR_LOCK1, ADDR_PROTECT} && hv && !busy) begin
      busy = 1;
      m_bits[a == ADDR_LOCK0 ? 2 : a == ADDR_LOCK1 ? 1 : 0] = op[1];
    end
    if (a inside {[4'h4:4'hE]}) m_err = 1;
    check(w0, 9'(m_w0));
    check(w1, 9'(m_w1));
    check({8'h00, err}, {8'h00, m_err});
  endtask
  task automatic settle();
    hv_spi_host_inst.release_cs();
    repeat (10) @(posedge sys_clk);
    for (int i = 0; i < 400 && flag !== 1'b0; i++) @(posedge sys_clk);
    busy  = 0;
    m_err = 0;
    check({5'h00, flag, bits}, {6'h00, m_bits});
    check({8'h00, err}, 9'h000);
    check({7'h00, sdo_o, sdo_oe}, 9'h002);
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  initial begin
    repeat (60000) @(posedge sys_clk);
    bad_count++;
    results();
  end
  initial begin
    nrst = 1'b0;
    m_w0 = 128;
    m_w1 = 128;
    m_bits = 3'h0;
    seed = $urandom(5759);
    repeat (5) @(posedge sys_clk);
    nrst <= 1'b1;
    repeat (5) @(posedge sys_clk);
    check(w0, 9'h080);
    check(w1, 9'h080);
    check({7'h00, sdo_o, sdo_oe}, 9'h002);
    check({5'h00, flag, bits}, 9'h000);
    for (int h = 0; h < 2; h++)
      for (int a = 0; a < 16; a++) begin
        hv_spi_host_inst.select(h[0]);
        cmd(a[3:0], 2'($urandom_range(1, 2)));
        settle();
      end
    hv_spi_host_inst.select(1'b0);
    for (int i = 0; i < 280; i++)
      cmd(i < 140 ? ADDR_WIPER0 : ADDR_WIPER1, i < 140 ? OP_DECREMENT
        : OP_INCREMENT);
    settle();
    hv_spi_host_inst.select(1'b1);
    cmd(ADDR_LOCK1, m_bits[1] ? OP_INCREMENT : OP_DECREMENT);
    check({8'h00, flag}, 9'h000);
    hv_spi_host_inst.release_cs();
    hv_spi_host_inst.select(1'b1);
    cmd(ADDR_WIPER1, OP_DECREMENT);
    check({8'h00, flag}, 9'h001);
    cmd(ADDR_PROTECT, m_bits[0] ? OP_INCREMENT : OP_DECREMENT);
    settle();
    hv_spi_host_inst.select(1'b1);
    cmd(ADDR_TERMINAL_CONTROL_REGISTER, OP_INCREMENT);
    hv_spi_host_inst.send(8'h00);
    repeat (5) @(posedge sys_clk);
    check({7'h00, sdo_o, sdo_oe}, 9'h001);
    settle();
    results();
  end
endmodule
`default_nettype wire
